/* rtl/safety_supervisor_map.svh */
`ifndef SAFETY_SUPERVISOR_MAP_SVH
`define SAFETY_SUPERVISOR_MAP_SVH

// register byte offsets
`define REG_CTRL        8'h00
`define REG_CMD         8'h04
`define REG_MARGIN      8'h08
`define REG_STATUS      8'h0C
`define REG_FAULT       8'h10

// reset values
`define CTRL_RST        9'h000
`define MARGIN_RST      16'h0100

// control fields
`define CTRL_STARTED    0
`define CTRL_SAVE_BUSY  1
`define CTRL_MODE_LO    2
`define CTRL_ERROR      5
`define CTRL_WARNING    6
`define CTRL_WDOG_EN    7
`define CTRL_W          9

// command bits, write-only pulses
`define CMD_SAVE_OK     0
`define CMD_SAVE_FAIL   1
`define CMD_DOOR_REL    2
`define CMD_ESTOP_REL   3
`define CMD_LOW_PWR     4
`define CMD_HIGH_PWR    5

// detector inputs, one bit each
`define DET_ENC_LOSS    0
`define DET_OVERLOAD    1
`define DET_TORQUE      2
`define DET_SPEED       3
`define DET_SPEED_OVF   4
`define DET_CHECKSUM    5
`define DET_OVERHEAT    6
`define DET_RLY_WELD    7
`define DET_RLY_JUNC    8
`define DET_RLY_OPEN    9
`define DET_OVERVOLT    10
`define DET_AC_DROP     11
`define DET_XCHECK      12
`define DET_TEMP        13
`define DET_FAN         14
`define DET_W           15
// sticky fault bits beyond the detectors
`define FLT_WDOG        15
`define FLT_POS         16
`define FLT_W           17
// faults that fire the brake: all but temperature and fan
`define FLT_BRAKE_MASK  17'h19FFF

// timing
`define CLK_KHZ         125000
`define SAVE_SHOW_MS    2000
`define BLINK_HALF_MS   250
`define WDOG_TIMEOUT_MS 100

`endif

/* rtl/safety_supervisor_pkg.sv */
package safety_supervisor_pkg;

  typedef enum logic [2:0] {
    MODE_IDLE    = 3'b000,
    MODE_TEACH   = 3'b001,
    MODE_AUTO    = 3'b010,
    MODE_PROGRAM = 3'b011,
    MODE_TEST    = 3'b100,
    MODE_RECOVER = 3'b101
  } op_mode_t;

  typedef enum logic [1:0] {
    PWR_NORMAL   = 2'b00,
    PWR_LOW      = 2'b01,
    PWR_PROHIBIT = 2'b10,
    PWR_ESTOP    = 2'b11
  } pwr_state_t;

endpackage

/* rtl/sync_2ff.sv */
`timescale 1ns/1ns
// two-stage synchroniser; first stage is read only by the second
module sync_2ff #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta;

  // reset to idle level so nothing trips during reset
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= d_i;
      q_o  <= meta;
    end
  end

endmodule

/* rtl/safety_supervisor.sv */
`timescale 1ns/1ns
`include "safety_supervisor_map.svh"

// Functional notes
// - blink teach, auto, program until startup done
// - blink teach, auto, program while saving status
// - save success: three lamps on 2 s, error off
// - save failure: all four lamps on 2 s
// - error steady, warning blinks, estop lamp follows
// - mode lamps blink; test mode lights teach steadily
// - recovery: error, teach, program on, auto off
// - supply drop lights teach and auto steadily
// - emergency stop cuts motor power at once
// - door open latches prohibit until closed, released
// - door open: teach plus enable allows low power
// - power-change command forces low power always
// - estop and drive faults fire dynamic brake
// - position error beyond margin fires brake
// - relay weld, junction, open faults fire brake
// - overvoltage and supply drop fire brake
// - watchdog expiry or cross-check mismatch fires brake
// - temperature and fan faults flagged, no brake
module safety_supervisor #(
  parameter int unsigned BLINK_HALF_CYCLES = `BLINK_HALF_MS * `CLK_KHZ,
  parameter int unsigned SAVE_SHOW_CYCLES  = `SAVE_SHOW_MS * `CLK_KHZ,
  parameter int unsigned WDOG_CYCLES       = `WDOG_TIMEOUT_MS * `CLK_KHZ
) (
  input  wire logic              CLK_SYS_I,
  input  wire logic              SRST_I,
  // axi4-lite slave
  input  wire logic [7:0]        AXI_AWADDR_I,
  input  wire logic              AXI_AWVALID_I,
  output logic                   AXI_AWREADY_O,
  input  wire logic [31:0]       AXI_WDATA_I,
  input  wire logic [3:0]        AXI_WSTRB_I,
  input  wire logic              AXI_WVALID_I,
  output logic                   AXI_WREADY_O,
  output logic [1:0]             AXI_BRESP_O,
  output logic                   AXI_BVALID_O,
  input  wire logic              AXI_BREADY_I,
  input  wire logic [7:0]        AXI_ARADDR_I,
  input  wire logic              AXI_ARVALID_I,
  output logic                   AXI_ARREADY_O,
  output logic [31:0]            AXI_RDATA_O,
  output logic [1:0]             AXI_RRESP_O,
  output logic                   AXI_RVALID_O,
  input  wire logic              AXI_RREADY_I,
  // pins from switches, detectors and motor processor
  input  wire logic [1:0]        ESTOP_I,
  input  wire logic              DOOR_OPEN_I,
  input  wire logic              TEACH_SEL_I,
  input  wire logic              ENABLE_SW_I,
  input  wire logic              WDOG_KICK_I,
  input  wire logic [`DET_W-1:0] DETECT_I,
  // positions from the servo logic on this clock
  input  wire logic [15:0]       POS_CMD_I,
  input  wire logic [15:0]       POS_ACT_I,
  // relays and lamps
  output logic                   MOTOR_PWR_O,
  output logic                   MOTION_EN_O,
  output logic                   LOW_POWER_O,
  output logic                   DBRAKE_O,
  output logic                   LED_ERROR_O,
  output logic                   LED_ESTOP_O,
  output logic                   LED_TEACH_O,
  output logic                   LED_AUTO_O,
  output logic                   LED_PROG_O
);

  localparam int PIN_W = 6 + `DET_W;

  // pin synchronisation
  logic [PIN_W-1:0]  pins_sync;
  logic [1:0]        estop_s;
  logic              door_s;
  logic              teach_s;
  logic              enable_s;
  logic              kick_s;
  logic [`DET_W-1:0] det_s;

  sync_2ff #(.W(PIN_W)) u_pin_sync (
    .clk_i  (CLK_SYS_I),
    .srst_i (SRST_I),
    .d_i    ({ESTOP_I, DOOR_OPEN_I, TEACH_SEL_I, ENABLE_SW_I, WDOG_KICK_I, DETECT_I}),
    .q_o    (pins_sync)
  );

  assign {estop_s, door_s, teach_s, enable_s, kick_s, det_s} = pins_sync;

  // register state
  logic [`CTRL_W-1:0]   ctrl;
  logic [15:0]          margin;
  logic [`FLT_W-1:0]    fault;
  safety_supervisor_pkg::pwr_state_t pwr_state;
  safety_supervisor_pkg::pwr_state_t next_pwr_state;
  safety_supervisor_pkg::op_mode_t   mode;

  // ---------------- axi4-lite slave ----------------
  logic        aw_full;
  logic        w_full;
  logic [7:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic [1:0]  b_resp;
  logic        b_valid;
  logic [31:0] r_data;
  logic [1:0]  r_resp;
  logic        r_valid;

  wire        aw_take  = AXI_AWVALID_I & AXI_AWREADY_O;
  wire        w_take   = AXI_WVALID_I & AXI_WREADY_O;
  wire        ar_take  = AXI_ARVALID_I & AXI_ARREADY_O;
  wire        wr_fire  = aw_full & w_full & ~b_valid;
  wire [31:0] wmask    = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  wire        wr_ctrl  = wr_fire & (aw_addr == `REG_CTRL);
  wire        wr_cmd   = wr_fire & (aw_addr == `REG_CMD);
  wire        wr_marg  = wr_fire & (aw_addr == `REG_MARGIN);
  wire        wr_flt   = wr_fire & (aw_addr == `REG_FAULT);
  wire        wr_known = wr_ctrl | wr_cmd | wr_marg | wr_flt | (aw_addr == `REG_STATUS);

  // one write at a time: address and data freed as the response is raised; the next write waits until it is taken
  assign AXI_AWREADY_O = ~aw_full;
  assign AXI_WREADY_O  = ~w_full;
  assign AXI_BVALID_O  = b_valid;
  assign AXI_BRESP_O   = b_resp;
  assign AXI_ARREADY_O = ~r_valid;
  assign AXI_RVALID_O  = r_valid;
  assign AXI_RDATA_O   = r_data;
  assign AXI_RRESP_O   = r_resp;

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_full <= 1'b1;
        aw_addr <= AXI_AWADDR_I;
      end else if (wr_fire) begin
        aw_full <= 1'b0;
      end
      if (w_take) begin
        w_full <= 1'b1;
        w_data <= AXI_WDATA_I;
        w_strb <= AXI_WSTRB_I;
      end else if (wr_fire) begin
        w_full <= 1'b0;
      end
    end
  end

  // write response; unmapped address answers slverr
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      b_valid <= 1'b0;
      b_resp  <= 2'b00;
    end else if (wr_fire) begin
      b_valid <= 1'b1;
      b_resp  <= wr_known ? 2'b00 : 2'b10;
    end else if (AXI_BREADY_I) begin
      b_valid <= 1'b0;
    end
  end

  // read mux
  logic [31:0] status_word;
  logic [31:0] rd_mux;
  logic        rd_known;

  assign status_word = {22'h000000, ~door_s, |estop_s, DBRAKE_O, pwr_state,
                        LED_PROG_O, LED_AUTO_O, LED_TEACH_O, LED_ESTOP_O, LED_ERROR_O};
  assign rd_known = (AXI_ARADDR_I == `REG_CTRL) | (AXI_ARADDR_I == `REG_CMD) |
                    (AXI_ARADDR_I == `REG_MARGIN) | (AXI_ARADDR_I == `REG_STATUS) |
                    (AXI_ARADDR_I == `REG_FAULT);
  assign rd_mux = (AXI_ARADDR_I == `REG_CTRL)   ? {23'h000000, ctrl} :
                  (AXI_ARADDR_I == `REG_MARGIN) ? {16'h0000, margin} :
                  (AXI_ARADDR_I == `REG_STATUS) ? status_word :
                  (AXI_ARADDR_I == `REG_FAULT)  ? {15'h0000, fault} : 32'h0000_0000;

  // read data registered, valid the cycle after the address is taken
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      r_valid <= 1'b0;
      r_data  <= 32'h0000_0000;
      r_resp  <= 2'b00;
    end else if (ar_take) begin
      r_valid <= 1'b1;
      r_data  <= rd_mux;
      r_resp  <= rd_known ? 2'b00 : 2'b10;
    end else if (AXI_RREADY_I) begin
      r_valid <= 1'b0;
    end
  end

  // ---------------- software registers ----------------
  logic [5:0] cmd;

  assign cmd  = wr_cmd ? w_data[5:0] & wmask[5:0] : 6'h00;
  assign mode = safety_supervisor_pkg::op_mode_t'(ctrl[`CTRL_MODE_LO +: 3]);

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      ctrl   <= `CTRL_RST;
      margin <= `MARGIN_RST;
    end else begin
      if (wr_ctrl) begin
        ctrl <= (ctrl & ~wmask[`CTRL_W-1:0]) | (w_data[`CTRL_W-1:0] & wmask[`CTRL_W-1:0]);
      end
      if (wr_marg) begin
        margin <= (margin & ~wmask[15:0]) | (w_data[15:0] & wmask[15:0]);
      end
    end
  end

  // ---------------- fault detection ----------------
  logic              kick_q;
  logic [31:0]       wdog_cnt;
  logic              wdog_exp;
  logic [16:0]       pos_diff;
  logic [15:0]       pos_abs;
  logic              pos_err;
  logic [`FLT_W-1:0] fault_set;
  logic [`FLT_W-1:0] fault_next;
  logic              brake_next;

  assign pos_diff = {1'b0, POS_CMD_I} - {1'b0, POS_ACT_I};
  assign pos_abs  = pos_diff[16] ? 16'(~pos_diff[15:0] + 16'h0001) : pos_diff[15:0];
  assign pos_err  = pos_abs > margin;
  assign wdog_exp = ctrl[`CTRL_WDOG_EN] & (wdog_cnt >= WDOG_CYCLES);

  // watchdog restarts on each rising kick from the motor processor
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      kick_q   <= 1'b0;
      wdog_cnt <= 32'h0000_0000;
    end else begin
      kick_q <= kick_s;
      if (~ctrl[`CTRL_WDOG_EN] | (kick_s & ~kick_q)) begin
        wdog_cnt <= 32'h0000_0000;
      end else if (~wdog_exp) begin
        wdog_cnt <= wdog_cnt + 32'h0000_0001;
      end
    end
  end

  // sticky faults: a set in the same cycle as a write-one-to-clear wins
  assign fault_set  = {pos_err, wdog_exp, det_s};
  assign fault_next = (fault & ~(wr_flt ? w_data[`FLT_W-1:0] & wmask[`FLT_W-1:0]
                                        : {`FLT_W{1'b0}})) | fault_set;
  // brake held while a latched fault inside FLT_BRAKE_MASK stands, so it cannot chatter on a noisy detector
  assign brake_next = |estop_s | (|(fault_next & `FLT_BRAKE_MASK));

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      fault    <= {`FLT_W{1'b0}};
      DBRAKE_O <= 1'b0;
    end else begin
      fault    <= fault_next;
      DBRAKE_O <= brake_next;
    end
  end

  // ---------------- power state ----------------
  wire door_bypass = door_s & teach_s & enable_s;

  always_comb begin
    next_pwr_state = pwr_state;
    if (|estop_s) begin
      next_pwr_state = safety_supervisor_pkg::PWR_ESTOP;
    end else begin
      unique case (pwr_state)
        safety_supervisor_pkg::PWR_NORMAL: begin
          if (door_s) begin
            next_pwr_state = safety_supervisor_pkg::PWR_PROHIBIT;
          end else if (cmd[`CMD_LOW_PWR]) begin
            next_pwr_state = safety_supervisor_pkg::PWR_LOW;
          end
        end
        safety_supervisor_pkg::PWR_LOW: begin
          if (door_s & ~door_bypass) begin
            next_pwr_state = safety_supervisor_pkg::PWR_PROHIBIT;
          end else if (cmd[`CMD_HIGH_PWR] & ~door_s & ~cmd[`CMD_LOW_PWR]) begin
            next_pwr_state = safety_supervisor_pkg::PWR_NORMAL;
          end
        end
        safety_supervisor_pkg::PWR_PROHIBIT: begin
          // leaving needs both a closed door and an explicit release
          if (~door_s & cmd[`CMD_DOOR_REL]) begin
            next_pwr_state = safety_supervisor_pkg::PWR_LOW;
          end
        end
        safety_supervisor_pkg::PWR_ESTOP: begin
          // restart from estop lands in low power, or in prohibit while the door is open
          if (cmd[`CMD_ESTOP_REL]) begin
            next_pwr_state = door_s ? safety_supervisor_pkg::PWR_PROHIBIT
                                    : safety_supervisor_pkg::PWR_LOW;
          end
        end
      endcase
    end
  end

  // relay outputs follow the next state so estop acts in the same edge
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      pwr_state   <= safety_supervisor_pkg::PWR_ESTOP;
      MOTOR_PWR_O <= 1'b0;
      MOTION_EN_O <= 1'b0;
      LOW_POWER_O <= 1'b1;
    end else begin
      pwr_state   <= next_pwr_state;
      MOTOR_PWR_O <= next_pwr_state != safety_supervisor_pkg::PWR_ESTOP;
      MOTION_EN_O <= (next_pwr_state != safety_supervisor_pkg::PWR_ESTOP) &
                     (door_bypass |
                      (next_pwr_state != safety_supervisor_pkg::PWR_PROHIBIT));
      LOW_POWER_O <= next_pwr_state != safety_supervisor_pkg::PWR_NORMAL;
    end
  end

  // ---------------- lamps ----------------
  logic [31:0] blink_cnt;
  logic        blink;
  logic [31:0] show_cnt;
  logic        show_fail;
  logic        show_on;

  // one shared blink phase for every lamp
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      blink_cnt <= 32'h0000_0000;
      blink     <= 1'b0;
    end else if (blink_cnt >= BLINK_HALF_CYCLES - 1) begin
      blink_cnt <= 32'h0000_0000;
      blink     <= ~blink;
    end else begin
      blink_cnt <= blink_cnt + 32'h0000_0001;
    end
  end

  // save result shown for a fixed time; a new result restarts it
  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      show_cnt  <= 32'h0000_0000;
      show_fail <= 1'b0;
    end else if (cmd[`CMD_SAVE_OK] | cmd[`CMD_SAVE_FAIL]) begin
      show_cnt  <= SAVE_SHOW_CYCLES;
      show_fail <= cmd[`CMD_SAVE_FAIL];
    end else if (show_on) begin
      show_cnt <= show_cnt - 32'h0000_0001;
    end
  end

  assign show_on = show_cnt != 32'h0000_0000;

  logic [4:0] lamps; // error, estop, teach, auto, program

  // priority: startup, save result, save busy, then live status
  always_comb begin
    lamps = 5'b00000;
    if (~ctrl[`CTRL_STARTED]) begin
      lamps = {2'b00, {3{blink}}};
    end else if (show_on) begin
      lamps = {show_fail, 4'b0111};
    end else if (ctrl[`CTRL_SAVE_BUSY]) begin
      lamps = {2'b00, {3{blink}}};
    end else begin
      lamps[4] = ctrl[`CTRL_ERROR] | (ctrl[`CTRL_WARNING] & blink);
      lamps[3] = pwr_state == safety_supervisor_pkg::PWR_ESTOP;
      if (det_s[`DET_AC_DROP]) begin
        lamps[2:0] = 3'b110;
      end else if (mode == safety_supervisor_pkg::MODE_RECOVER) begin
        lamps[4]   = 1'b1;
        lamps[2:0] = 3'b101;
      end else if (mode == safety_supervisor_pkg::MODE_TEST) begin
        lamps[2:0] = 3'b100;
      end else begin
        lamps[2] = (mode == safety_supervisor_pkg::MODE_TEACH) & blink;
        lamps[1] = (mode == safety_supervisor_pkg::MODE_AUTO) & blink;
        lamps[0] = (mode == safety_supervisor_pkg::MODE_PROGRAM) & blink;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I) begin
    if (SRST_I) begin
      {LED_ERROR_O, LED_ESTOP_O, LED_TEACH_O, LED_AUTO_O, LED_PROG_O} <= 5'b00000;
    end else begin
      {LED_ERROR_O, LED_ESTOP_O, LED_TEACH_O, LED_AUTO_O, LED_PROG_O} <= lamps;
    end
  end

endmodule

/* testbench/safety_supervisor_chk_sva.sv */
`timescale 1ns/1ns
`include "safety_supervisor_map.svh"
// field pins land three edges after sampling, so antecedents hold that long
module safety_supervisor_chk (
  input wire logic              CLK_SYS_I,
  input wire logic              SRST_I,
  input wire logic              AXI_ARREADY_O,
  input wire logic [1:0]        AXI_BRESP_O,
  input wire logic              AXI_BVALID_O,
  input wire logic              AXI_BREADY_I,
  input wire logic [31:0]       AXI_RDATA_O,
  input wire logic              AXI_RVALID_O,
  input wire logic              AXI_RREADY_I,
  input wire logic [1:0]        ESTOP_I,
  input wire logic              DOOR_OPEN_I,
  input wire logic              TEACH_SEL_I,
  input wire logic              ENABLE_SW_I,
  input wire logic [`DET_W-1:0] DETECT_I,
  input wire logic              MOTOR_PWR_O,
  input wire logic              MOTION_EN_O,
  input wire logic              LOW_POWER_O,
  input wire logic              DBRAKE_O,
  input wire logic              LED_ESTOP_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (SRST_I);
  // stop inputs
  chk_estop_cut: assert property ((ESTOP_I != 2'b00)[*3] |=> !MOTOR_PWR_O)
    else $error("motor power stayed on after stop input");
  chk_estop_brake: assert property ((ESTOP_I != 2'b00)[*3] |=> DBRAKE_O)
    else $error("brake missing after stop input");
  // temperature and fan bits are left out on purpose
  chk_fault_brake: assert property (
    (DETECT_I[12:0] != 13'h0000)[*3] |-> ##[1:2] DBRAKE_O)
    else $error("brake missing after fault detector");
  chk_estop_lamp: assert property (LED_ESTOP_O |-> $past(!MOTOR_PWR_O))
    else $error("stop lamp lit with power on");
  // door without pendant bypass stops motion; bypass only at low power
  chk_door_stop: assert property (
    (DOOR_OPEN_I && !(TEACH_SEL_I && ENABLE_SW_I))[*5] |=> !MOTION_EN_O)
    else $error("motion allowed with door open");
  chk_door_lowpwr: assert property (DOOR_OPEN_I[*5] ##0 MOTION_EN_O |-> LOW_POWER_O)
    else $error("door bypass motion not at low power");
  // bus answers stand until taken
  chk_bresp_hold: assert property (AXI_BVALID_O && !AXI_BREADY_I |=>
    AXI_BVALID_O && $stable(AXI_BRESP_O))
    else $error("write response dropped before taken");
  chk_rdata_hold: assert property (AXI_RVALID_O && !AXI_RREADY_I |=>
    AXI_RVALID_O && $stable(AXI_RDATA_O))
    else $error("read data dropped before taken");
  chk_read_block: assert property (AXI_RVALID_O |-> !AXI_ARREADY_O)
    else $error("read address accepted while data pending");
  // a taken read answer must not be repeated
  chk_read_drop: assert property (AXI_RVALID_O && AXI_RREADY_I |=> !AXI_RVALID_O)
    else $error("read answer repeated after taken");
  cover property ((ESTOP_I != 2'b00) ##3 DBRAKE_O);
  cover property (DOOR_OPEN_I && MOTION_EN_O);
  cover property (AXI_RVALID_O && !AXI_RREADY_I);
endmodule

bind safety_supervisor safety_supervisor_chk chk_i (
  .CLK_SYS_I(CLK_SYS_I), .SRST_I(SRST_I), .AXI_ARREADY_O(AXI_ARREADY_O),
  .AXI_BRESP_O(AXI_BRESP_O), .AXI_BVALID_O(AXI_BVALID_O), .AXI_BREADY_I(AXI_BREADY_I),
  .AXI_RDATA_O(AXI_RDATA_O), .AXI_RVALID_O(AXI_RVALID_O), .AXI_RREADY_I(AXI_RREADY_I),
  .ESTOP_I(ESTOP_I), .DOOR_OPEN_I(DOOR_OPEN_I), .TEACH_SEL_I(TEACH_SEL_I),
  .ENABLE_SW_I(ENABLE_SW_I), .DETECT_I(DETECT_I), .MOTOR_PWR_O(MOTOR_PWR_O),
  .MOTION_EN_O(MOTION_EN_O), .LOW_POWER_O(LOW_POWER_O), .DBRAKE_O(DBRAKE_O),
  .LED_ESTOP_O(LED_ESTOP_O));

/* testbench/safety_field_model.sv */
`timescale 1ns/1ns
// switches, detectors and motor processor; outputs change only on clock edges
module safety_field_model (
  input  wire logic        clk_i,
  input  wire logic [1:0]  estop_i,
  input  wire logic [2:0]  pend_i,
  input  wire logic        kick_run_i,
  input  wire logic [14:0] det_i,
  output logic [1:0]       estop_o,
  output logic             door_open_o,
  output logic             teach_sel_o,
  output logic             enable_sw_o,
  output logic             kick_o,
  output logic [14:0]      detect_o
);
  logic [1:0] kick_cnt;
  // defined levels before the first edge
  initial begin
    estop_o = 2'h0;
    {door_open_o, teach_sel_o, enable_sw_o, kick_o} = 4'h0;
    detect_o = 15'h0000;
    kick_cnt = 2'h0;
  end
  // motor processor kicks every fourth cycle while alive; stalling it starves the timer
  always @(posedge clk_i) begin
    kick_cnt <= kick_cnt + 2'h1;
    kick_o <= kick_run_i & kick_cnt[1];
    estop_o <= estop_i;
    {door_open_o, teach_sel_o, enable_sw_o} <= pend_i;
    detect_o <= det_i;
  end
endmodule

/* testbench/tb_top.sv */
`timescale 1ns/1ns
`include "safety_supervisor_map.svh"
module tb_top;
  logic        clk, srst, aw_valid, w_valid, b_ready, ar_valid, r_ready, kick_run;
  logic        aw_ready, w_ready, b_valid, ar_ready, r_valid, kick_w, door_w, teach_w, en_w;
  logic        motor_pwr, motion_en, low_pwr, dbrake, led_err, led_estop;
  logic        led_teach, led_auto, led_prog;
  logic [7:0]  aw_addr, ar_addr;
  logic [31:0] w_data, r_data;
  logic [1:0]  b_resp, r_resp, est, estop_w;
  logic [2:0]  pend;
  logic [14:0] det, detect_w;
  logic [15:0] pos_cmd, pos_act;
  logic [31:0] mode_ctrl [10] = '{32'h05, 32'h09, 32'h0D, 32'h11, 32'h15, 32'h25, 32'h49,
                                  32'h07, 32'h04, 32'h01};
  logic [7:0]  mode_lamp [10] = '{8'h20, 8'h08, 8'h02, 8'h10, 8'h51, 8'h60, 8'h88, 8'h2A,
                                  8'h2A, 8'h00};
  int          fails, total_checks;

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  safety_field_model field (.clk_i(clk), .estop_i(est), .pend_i(pend), .kick_run_i(kick_run),
    .det_i(det), .estop_o(estop_w), .door_open_o(door_w), .teach_sel_o(teach_w),
    .enable_sw_o(en_w), .kick_o(kick_w), .detect_o(detect_w));

  // short counts keep blink, save display and watchdog within a brief run
  safety_supervisor #(.BLINK_HALF_CYCLES(4), .SAVE_SHOW_CYCLES(20), .WDOG_CYCLES(16)) uut (
    .CLK_SYS_I(clk), .SRST_I(srst), .AXI_AWADDR_I(aw_addr), .AXI_AWVALID_I(aw_valid),
    .AXI_AWREADY_O(aw_ready), .AXI_WDATA_I(w_data), .AXI_WSTRB_I(4'hF),
    .AXI_WVALID_I(w_valid), .AXI_WREADY_O(w_ready), .AXI_BRESP_O(b_resp),
    .AXI_BVALID_O(b_valid), .AXI_BREADY_I(b_ready), .AXI_ARADDR_I(ar_addr),
    .AXI_ARVALID_I(ar_valid), .AXI_ARREADY_O(ar_ready), .AXI_RDATA_O(r_data),
    .AXI_RRESP_O(r_resp), .AXI_RVALID_O(r_valid), .AXI_RREADY_I(r_ready),
    .ESTOP_I(estop_w), .DOOR_OPEN_I(door_w), .TEACH_SEL_I(teach_w), .ENABLE_SW_I(en_w),
    .WDOG_KICK_I(kick_w), .DETECT_I(detect_w), .POS_CMD_I(pos_cmd), .POS_ACT_I(pos_act),
    .MOTOR_PWR_O(motor_pwr), .MOTION_EN_O(motion_en), .LOW_POWER_O(low_pwr),
    .DBRAKE_O(dbrake), .LED_ERROR_O(led_err), .LED_ESTOP_O(led_estop),
    .LED_TEACH_O(led_teach), .LED_AUTO_O(led_auto), .LED_PROG_O(led_prog));

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("FAIL t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // a spent wait counts as a mismatch and ends the run
  task automatic guard(inout int n);
    n++;
    if (n > 200) begin
      fails++;
      print_verdict();
    end
  endtask

  task automatic wait_for(input bit rd_side);
    int n = 0;
    do begin
      @(posedge clk);
      guard(n);
    end while ((rd_side ? r_valid : b_valid) !== 1'b1);
  endtask

  // ready raised only once the answer shows, so the slave must hold it a cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ap = 1'b1;
    logic dp = 1'b1;
    int   n = 0;
    aw_addr <= a;
    w_data <= d;
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    while (ap || dp) begin
      @(posedge clk);
      guard(n);
      if (ap && aw_ready) begin
        ap = 1'b0;
        aw_valid <= 1'b0;
      end
      if (dp && w_ready) begin
        dp = 1'b0;
        w_valid <= 1'b0;
      end
    end
    wait_for(1'b0);
    b_ready <= 1'b1;
    @(posedge clk);
    chk(b_resp, er);
    b_ready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp,
                    input logic [1:0] er);
    int n = 0;
    ar_addr <= a;
    ar_valid <= 1'b1;
    do begin
      @(posedge clk);
      guard(n);
    end while (ar_ready !== 1'b1);
    ar_valid <= 1'b0;
    wait_for(1'b1);
    r_ready <= 1'b1;
    @(posedge clk);
    chk(r_data & m, exp);
    chk(r_resp, er);
    r_ready <= 1'b0;
  endtask

  // lamp codes per lamp {error, teach, auto, program}: 0 off, 1 steady, 2 blinking
  task automatic obs(input logic [7:0] exp, input int len);
    logic [3:0] on = 4'h0;
    logic [3:0] off = 4'h0;
    logic [7:0] got;
    tick(3);
    repeat (len) begin
      @(posedge clk);
      on = on | {led_err, led_teach, led_auto, led_prog};
      off = off | ~{led_err, led_teach, led_auto, led_prog};
    end
    for (int k = 0; k < 4; k++)
      got[2*k +: 2] = (on[k] && off[k]) ? 2'h2 : {1'b0, on[k]};
    chk(got, exp);
  endtask

  // main sequence
  initial begin
    {srst, aw_valid, w_valid, b_ready, ar_valid, r_ready, kick_run} = 7'h40;
    {aw_addr, ar_addr, w_data, est, pend, det} = 68'h0;
    {pos_cmd, pos_act} = 32'h0;
    tick(3);
    chk({motor_pwr, low_pwr, dbrake}, 3'h2);
    srst <= 1'b0;
    rd(`REG_CTRL, 32'hFFFFFFFF, 32'h0, 2'h0);
    rd(`REG_MARGIN, 32'hFFFFFFFF, 32'h100, 2'h0);
    rd(`REG_CMD, 32'hFFFFFFFF, 32'h0, 2'h0);
    rd(8'h14, 32'hFFFFFFFF, 32'h0, 2'h2);
    wr(8'h14, 32'hFF, 2'h2);
    rd(`REG_STATUS, 32'h60, 32'h60, 2'h0);
    wr(`REG_CMD, 32'h08, 2'h0);
    rd(`REG_STATUS, 32'h60, 32'h20, 2'h0);
    wr(`REG_CMD, 32'h20, 2'h0);
    rd(`REG_STATUS, 32'h60, 32'h00, 2'h0);
    wr(`REG_CMD, 32'h10, 2'h0);
    rd(`REG_STATUS, 32'h60, 32'h20, 2'h0);
    for (int i = 0; i < 10; i++) begin
      wr(`REG_CTRL, mode_ctrl[i], 2'h0);
      obs(mode_lamp[i], 12);
    end
    wr(`REG_CTRL, 32'h25, 2'h0);
    wr(`REG_CMD, 32'h01, 2'h0);
    obs(8'h15, 10);
    tick(25);
    wr(`REG_CMD, 32'h02, 2'h0);
    obs(8'h55, 10);
    tick(25);
    obs(8'h60, 12);
    wr(`REG_CMD, 32'h20, 2'h0);
    pend <= 3'h4;
    tick(6);
    chk(motion_en, 1'b0);
    pend <= 3'h7;
    tick(6);
    chk({motion_en, low_pwr}, 2'h3);
    pend <= 3'h0;
    tick(6);
    chk(motion_en, 1'b0);
    rd(`REG_STATUS, 32'h60, 32'h40, 2'h0);
    wr(`REG_CMD, 32'h04, 2'h0);
    rd(`REG_STATUS, 32'h60, 32'h20, 2'h0);
    wr(`REG_CTRL, 32'h05, 2'h0);
    for (int i = 0; i < 15; i++) begin
      det <= 15'(1 << i);
      tick(6);
      chk(dbrake, i < 13);
      if (i == 11)
        obs(8'h14, 12);
      rd(`REG_FAULT, 32'h1FFFF, 32'(1 << i), 2'h0);
      det <= 15'h0000;
      tick(4);
      wr(`REG_FAULT, 32'(1 << i), 2'h0);
      tick(2);
      chk(dbrake, 1'b0);
    end
    est <= 2'h2;
    tick(6);
    chk({motor_pwr, dbrake, led_estop}, 3'h3);
    est <= 2'h0;
    tick(4);
    wr(`REG_CMD, 32'h08, 2'h0);
    tick(2);
    chk({motor_pwr, dbrake}, 2'h2);
    pos_cmd <= 16'h1000;
    pos_act <= 16'h1100;
    tick(4);
    chk(dbrake, 1'b0);
    pos_act <= 16'h0EFF;
    tick(4);
    chk(dbrake, 1'b1);
    rd(`REG_FAULT, 32'h1FFFF, 32'h10000, 2'h0);
    pos_act <= 16'h1000;
    wr(`REG_FAULT, 32'h10000, 2'h0);
    kick_run <= 1'b1;
    wr(`REG_CTRL, 32'h85, 2'h0);
    tick(60);
    rd(`REG_FAULT, 32'h1FFFF, 32'h0, 2'h0);
    kick_run <= 1'b0;
    tick(30);
    chk(dbrake, 1'b1);
    rd(`REG_FAULT, 32'h8000, 32'h8000, 2'h0);
    print_verdict();
  end
endmodule
